/* design/usbrp_consts.vh */
// Overview of operation
// - Two paths join inner and outer ports; bypass passes LS, FS, BC.
// - High-speed packets are resynchronized and resent on the opposite port.
// - Path choice is automatic, made by the internal line-state monitor.
// - While chip reset is low, both paths stop and outer port floats.
// - After reset release, startup lasts 10 ms, then disconnect state.
// - Startup and disconnect states join ports through the bypass switch.
// - Enable high moves disconnect to full/low-speed state, bypass kept.
// - Serial select high turns trim pins into a two-wire slave port.
// - Two-bit open-drain status output reports the internal state.
// - Monitor tracks device chirp K and host K-J before switching.
// - SE0 after the chirps ends handshake; enter high-speed, resync path.
// - Enable low after startup returns to disconnect, ports stay joined.
`ifndef USBRP_CONSTS_VH
`define USBRP_CONSTS_VH
`define USBRP_CLK_NS 40
`define USBRP_STARTUP_MS 10
`define USBRP_STARTUP_CYC ((`USBRP_STARTUP_MS * 1000000) / `USBRP_CLK_NS)
`define USBRP_ST_RESET 3'h0
`define USBRP_ST_STARTUP 3'h1
`define USBRP_ST_DISC 3'h2
`define USBRP_ST_FSLS 3'h3
`define USBRP_ST_HS 3'h4
`define USBRP_LS_SE0 2'h0
`define USBRP_LS_J 2'h1
`define USBRP_LS_K 2'h2
`define USBRP_CH_IDLE 3'h0
`define USBRP_CH_RST 3'h1
`define USBRP_CH_DEVK 3'h2
`define USBRP_CH_HK 3'h3
`define USBRP_CH_HJ 3'h4
`define USBRP_CHIRP_PAIRS 3'h3
`define USBRP_STAT_RESET 2'h0
`define USBRP_STAT_DISC 2'h1
`define USBRP_STAT_FSLS 2'h2
`define USBRP_STAT_HS 2'h3
`define USBRP_APB_CTRL 12'h000
`define USBRP_APB_STAT 12'h004
`define USBRP_APB_CHIRP 12'h008
`define USBRP_CTRL_RST 32'h0000_0000
`endif

/* design/usbrp_path_ctrl.v */
`timescale 1ns/100ps
`include "usbrp_consts.vh"
module usbrp_path_ctrl #(
  parameter STARTUP_CYC = `USBRP_STARTUP_CYC
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire chip_reset_n,
  input wire enable,
  input wire force_through_strap,
  input wire detach_state_enable,
  input wire serial_config_select,
  input wire [1:0] inner_line_state,
  input wire [1:0] outer_line_state,
  input wire [4:0] tx_current_trim_in,
  output wire [4:0] tx_current_trim_out,
  output wire [4:0] tx_current_trim_oe_n,
  output wire [2:0] serial_slave_addr,
  output wire serial_scl_in,
  output wire serial_sda_in,
  output reg bypass_path_on,
  output reg highspeed_resync_path,
  output reg outer_port_hiz,
  output wire [1:0] state_indicator_out,
  output wire [1:0] state_indicator_oe_n
);

// ------------------------------------------------------------
// Input synchronisers
// ------------------------------------------------------------
// Three stages; a change is accepted once stages two and three agree
reg [2:0] rst_sy_r;
reg [2:0] en_sy_r;
reg [2:0] ils_a_r;
reg [2:0] ils_b_r;
reg [2:0] ols_a_r;
reg [2:0] ols_b_r;
reg rst_q_r;
reg en_q_r;
reg [1:0] ils_q_r;
reg [1:0] ols_q_r;

always @(posedge pclk or negedge presetn)
begin
  if (!presetn)
  begin
    rst_sy_r <= 3'h0;
    en_sy_r <= 3'h0;
    ils_a_r <= 3'h0;
    ils_b_r <= 3'h0;
    ols_a_r <= 3'h0;
    ols_b_r <= 3'h0;
    rst_q_r <= 1'b0;
    en_q_r <= 1'b0;
    ils_q_r <= 2'h0;
    ols_q_r <= 2'h0;
  end
  else
  begin
    rst_sy_r <= {rst_sy_r[1:0], chip_reset_n};
    en_sy_r <= {en_sy_r[1:0], enable};
    ils_a_r <= {ils_a_r[1:0], inner_line_state[0]};
    ils_b_r <= {ils_b_r[1:0], inner_line_state[1]};
    ols_a_r <= {ols_a_r[1:0], outer_line_state[0]};
    ols_b_r <= {ols_b_r[1:0], outer_line_state[1]};
    if (rst_sy_r[2] == rst_sy_r[1])
      rst_q_r <= rst_sy_r[2];
    if (en_sy_r[2] == en_sy_r[1])
      en_q_r <= en_sy_r[2];
    if (ils_a_r[2] == ils_a_r[1] && ils_b_r[2] == ils_b_r[1])
      ils_q_r <= {ils_b_r[2], ils_a_r[2]};
    if (ols_a_r[2] == ols_a_r[1] && ols_b_r[2] == ols_b_r[1])
      ols_q_r <= {ols_b_r[2], ols_a_r[2]};
  end
end

// ------------------------------------------------------------
// Control register
// ------------------------------------------------------------
// Bit 0 blocks entry to high-speed state (bypass only) for bring-up; once in high-speed it has no effect
reg [31:0] ctrl_r;
wire apb_wr;
wire hs_inhibit;

assign apb_wr = psel & penable & pwrite;
assign pready = 1'b1;
assign pslverr = 1'b0;
assign hs_inhibit = ctrl_r[0];

always @(posedge pclk or negedge presetn)
begin
  if (!presetn)
    ctrl_r <= `USBRP_CTRL_RST;
  else if (apb_wr && paddr == `USBRP_APB_CTRL)
    ctrl_r <= {31'h0, pwdata[0]};
end

// ------------------------------------------------------------
// Main state machine
// ------------------------------------------------------------
reg [2:0] state_r;
reg [2:0] state_nxt;
reg [31:0] tmr_r;
reg [2:0] chirp_r;
reg [2:0] chirp_nxt;
reg [2:0] kj_cnt_r;
reg chirp_done_r;
wire startup_done;

assign startup_done = (tmr_r >= STARTUP_CYC - 1);

always @*
begin
  state_nxt = state_r;
  case (state_r)
    `USBRP_ST_RESET:
      if (rst_q_r)
        state_nxt = `USBRP_ST_STARTUP;
    `USBRP_ST_STARTUP:
      if (startup_done)
        state_nxt = `USBRP_ST_DISC;
    `USBRP_ST_DISC:
      if (en_q_r)
        state_nxt = `USBRP_ST_FSLS;
    `USBRP_ST_FSLS:
      if (chirp_done_r && ols_q_r == `USBRP_LS_SE0 && !hs_inhibit)
        state_nxt = `USBRP_ST_HS;
    `USBRP_ST_HS:
      state_nxt = `USBRP_ST_HS;
    default:
      state_nxt = `USBRP_ST_RESET;
  endcase
  if (state_r != `USBRP_ST_RESET && state_r != `USBRP_ST_STARTUP &&
      !en_q_r)
    state_nxt = `USBRP_ST_DISC;
  if (!rst_q_r)
    state_nxt = `USBRP_ST_RESET;
end

always @(posedge pclk or negedge presetn)
begin
  if (!presetn)
  begin
    state_r <= `USBRP_ST_RESET;
    tmr_r <= 32'h0;
  end
  else
  begin
    state_r <= state_nxt;
    if (state_r == `USBRP_ST_STARTUP && state_nxt == `USBRP_ST_STARTUP)
      tmr_r <= tmr_r + 32'h1;
    else
      tmr_r <= 32'h0;
  end
end

// ------------------------------------------------------------
// Chirp tracker
// ------------------------------------------------------------
// Device K on the outer port, then alternating host K and J
always @*
begin
  chirp_nxt = chirp_r;
  case (chirp_r)
    `USBRP_CH_IDLE:
      if (ils_q_r == `USBRP_LS_SE0)
        chirp_nxt = `USBRP_CH_RST;
    `USBRP_CH_RST:
      if (ols_q_r == `USBRP_LS_K)
        chirp_nxt = `USBRP_CH_DEVK;
    `USBRP_CH_DEVK:
      if (ils_q_r == `USBRP_LS_SE0)
        chirp_nxt = `USBRP_CH_DEVK;
      else if (ils_q_r == `USBRP_LS_J)
        chirp_nxt = `USBRP_CH_HJ;
      else
        chirp_nxt = `USBRP_CH_DEVK;
    `USBRP_CH_HJ:
      if (ils_q_r == `USBRP_LS_K)
        chirp_nxt = `USBRP_CH_HK;
    `USBRP_CH_HK:
      if (ils_q_r == `USBRP_LS_J)
        chirp_nxt = `USBRP_CH_HJ;
    default:
      chirp_nxt = `USBRP_CH_IDLE;
  endcase
end

always @(posedge pclk or negedge presetn)
begin
  if (!presetn)
  begin
    chirp_r <= `USBRP_CH_IDLE;
    kj_cnt_r <= 3'h0;
    chirp_done_r <= 1'b0;
  end
  else if (state_r != `USBRP_ST_FSLS)
  begin
    chirp_r <= `USBRP_CH_IDLE;
    kj_cnt_r <= 3'h0;
    chirp_done_r <= 1'b0;
  end
  else
  begin
    chirp_r <= chirp_nxt;
    // One host K-J pair counted per J after K
    if (chirp_r == `USBRP_CH_HK && chirp_nxt == `USBRP_CH_HJ &&
        kj_cnt_r != `USBRP_CHIRP_PAIRS)
      kj_cnt_r <= kj_cnt_r + 3'h1;
    if (kj_cnt_r == `USBRP_CHIRP_PAIRS)
      chirp_done_r <= 1'b1;
  end
end

// ------------------------------------------------------------
// Path selection and status
// ------------------------------------------------------------
// Force-through is board-tied low; it only pins the bypass if set
reg [1:0] stat_r;

always @(posedge pclk or negedge presetn)
begin
  if (!presetn)
  begin
    bypass_path_on <= 1'b0;
    highspeed_resync_path <= 1'b0;
    outer_port_hiz <= 1'b1;
    stat_r <= `USBRP_STAT_RESET;
  end
  else
  begin
    case (state_nxt)
      `USBRP_ST_RESET:
      begin
        bypass_path_on <= 1'b0;
        highspeed_resync_path <= 1'b0;
        outer_port_hiz <= 1'b1;
        stat_r <= `USBRP_STAT_RESET;
      end
      `USBRP_ST_HS:
      begin
        bypass_path_on <= force_through_strap;
        highspeed_resync_path <= ~force_through_strap;
        outer_port_hiz <= 1'b0;
        stat_r <= `USBRP_STAT_HS;
      end
      `USBRP_ST_FSLS:
      begin
        bypass_path_on <= 1'b1;
        highspeed_resync_path <= 1'b0;
        outer_port_hiz <= 1'b0;
        stat_r <= `USBRP_STAT_FSLS;
      end
      default:
      begin
        bypass_path_on <= 1'b1;
        highspeed_resync_path <= 1'b0;
        outer_port_hiz <= 1'b0;
        stat_r <= `USBRP_STAT_DISC;
      end
    endcase
  end
end

// Open drain: oe_n low pulls the pin low, otherwise it floats
assign state_indicator_out = 2'h0;
assign state_indicator_oe_n = ~stat_r;

// ------------------------------------------------------------
// Trim pins as two-wire slave port
// ------------------------------------------------------------
// Block never drives these pins; the serial engine lives elsewhere
assign tx_current_trim_out = 5'h0;
assign tx_current_trim_oe_n = 5'h1f;
assign serial_slave_addr = serial_config_select ?
                           tx_current_trim_in[2:0] : 3'h0;
assign serial_scl_in = serial_config_select ?
                       tx_current_trim_in[3] : 1'b1;
assign serial_sda_in = serial_config_select ?
                       tx_current_trim_in[4] : 1'b1;

// ------------------------------------------------------------
// Register read
// ------------------------------------------------------------
always @(posedge pclk or negedge presetn)
begin
  if (!presetn)
    prdata <= 32'h0;
  else if (psel && !penable && !pwrite)
  begin
    case (paddr)
      `USBRP_APB_CTRL:
        prdata <= ctrl_r;
      `USBRP_APB_STAT:
        prdata <= {24'h0, detach_state_enable, serial_config_select,
                   en_q_r, highspeed_resync_path, bypass_path_on,
                   state_r};
      `USBRP_APB_CHIRP:
        prdata <= {25'h0, chirp_done_r, kj_cnt_r, chirp_r};
      default:
        prdata <= 32'h0;
    endcase
  end
end

endmodule

/* sim/usbrp_far_model.sv */
`timescale 1ns/100ps
// ----
// Host and plugged device line drivers
// ----
module usbrp_far_model (
  input wire pclk,
  input wire [1:0] host_ls,
  input wire [1:0] dev_ls,
  output reg [1:0] inner_line_state,
  output reg [1:0] outer_line_state
);
  // Bus reset SE0 and chirps come from the bench sequence
  always @(posedge pclk)
  begin
    inner_line_state <= host_ls;
    outer_line_state <= dev_ls;
  end
endmodule

/* sim/usbrp_path_monitor.sv */
`timescale 1ns/100ps
module usbrp_monitor (
  input wire pclk,
  input wire presetn,
  input wire chip_reset_n,
  input wire enable,
  input wire force_through_strap,
  input wire serial_config_select,
  input wire [4:0] tx_current_trim_in,
  input wire [2:0] serial_slave_addr,
  input wire serial_scl_in,
  input wire serial_sda_in,
  input wire bypass_path_on,
  input wire highspeed_resync_path,
  input wire outer_port_hiz,
  input wire [1:0] state_indicator_out,
  input wire [1:0] state_indicator_oe_n
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_RST_HIZ: assert property ((!chip_reset_n)[*8] |-> outer_port_hiz
    && !bypass_path_on && !highspeed_resync_path) else $error("reset path");
  AST_ONE_PATH: assert property (!force_through_strap
    |-> !(bypass_path_on && highspeed_resync_path)) else $error("two paths");
  AST_SER_MAP: assert property (serial_config_select |->
    {serial_sda_in, serial_scl_in, serial_slave_addr} == tx_current_trim_in)
    else $error("serial pins");
  AST_OD_LOW: assert property (state_indicator_out == 2'h0)
    else $error("indicator drives high");
  AST_JOINED: assert property (bypass_path_on |-> !outer_port_hiz)
    else $error("bypass on but floating");
  AST_EN_LOW: assert property ((chip_reset_n && !enable)[*8] |->
    bypass_path_on && !highspeed_resync_path) else $error("enable low");
  AST_HS_SWAP: assert property ($rose(highspeed_resync_path) |->
    $fell(bypass_path_on)) else $error("path swap");
  AST_HS_IND: assert property (highspeed_resync_path[*2] |->
    state_indicator_oe_n == 2'h0) else $error("hs indicator");
endmodule

/* sim/tb_usbrp_path_control.sv */
`timescale 1ns/100ps
`include "usbrp_consts.vh"
module tb_usbrp_path_control;
  reg pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  reg [11:0] paddr = 12'h000;
  reg [31:0] pwdata = 32'h0;
  reg chip_reset_n = 0, enable = 0, serial_config_select = 0;
  reg [4:0] tx_current_trim_in = 5'h15;
  reg [1:0] host_ls = `USBRP_LS_J, dev_ls = `USBRP_LS_J;
  wire [31:0] prdata;
  wire pready, pslverr, serial_scl_in, serial_sda_in, outer_port_hiz;
  wire bypass_path_on, highspeed_resync_path;
  wire [2:0] serial_slave_addr;
  wire [4:0] trim_out, trim_oe_n;
  wire [1:0] inner_line_state, outer_line_state, state_indicator_oe_n;
  integer bad_count = 0, num_checks = 0, n;
  always #20 pclk = ~pclk;
  usbrp_path_ctrl #(.STARTUP_CYC(20)) dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .chip_reset_n(chip_reset_n), .enable(enable),
    .force_through_strap(1'b0),
    .detach_state_enable(1'b0),
    .serial_config_select(serial_config_select),
    .inner_line_state(inner_line_state), .outer_line_state(outer_line_state),
    .tx_current_trim_in(tx_current_trim_in), .tx_current_trim_out(trim_out),
    .tx_current_trim_oe_n(trim_oe_n), .serial_slave_addr(serial_slave_addr),
    .serial_scl_in(serial_scl_in), .serial_sda_in(serial_sda_in),
    .bypass_path_on(bypass_path_on), .outer_port_hiz(outer_port_hiz),
    .highspeed_resync_path(highspeed_resync_path), .state_indicator_out(),
    .state_indicator_oe_n(state_indicator_oe_n));
  usbrp_far_model far (.pclk(pclk), .host_ls(host_ls), .dev_ls(dev_ls),
    .inner_line_state(inner_line_state), .outer_line_state(outer_line_state));
  // ----
  // Bus tasks
  // ----
  task final_report;
  begin
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  end
  endtask
  task chk(input string nm, input [31:0] e, input [31:0] g);
  begin
    num_checks = num_checks + 1;
    if (g !== e)
    begin
      bad_count = bad_count + 1;
      $display("wrong value %s exp %h got %h", nm, e, g);
    end
  end
  endtask
  task apb(input w, input [11:0] a, input [31:0] d, input [31:0] m,
    input [31:0] e);
  begin
    psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk) penable <= 1;
    n = 0;
    @(posedge pclk);
    // Each access edge is judged by pready as it stood at that edge
    while (pready !== 1'b1 && n < 20)
    begin
      n = n + 1;
      @(posedge pclk);
    end
    if (n == 20)
    begin
      bad_count = bad_count + 1;
      final_report;
    end
    // Read data is taken at the edge where pready is seen high
    if (!w)
      chk("prdata", e, prdata & m);
    chk("pslverr", 0, pslverr);
    psel <= 0; penable <= 0;
    @(posedge pclk);
  end
  endtask
  task ls(input [1:0] h, input [1:0] d);
  begin
    host_ls <= h; dev_ls <= d;
    repeat (8) @(posedge pclk);
  end
  endtask
  task chirp(input [31:0] e);
  begin
    ls(`USBRP_LS_SE0, `USBRP_LS_SE0);
    ls(`USBRP_LS_K, `USBRP_LS_K);
    repeat (3)
    begin
      ls(`USBRP_LS_J, `USBRP_LS_J);
      ls(`USBRP_LS_K, `USBRP_LS_K);
    end
    ls(`USBRP_LS_J, `USBRP_LS_J);
    apb(0, `USBRP_APB_CHIRP, 0, 32'h40, 32'h40);
    apb(0, `USBRP_APB_STAT, 0, 32'h1f, 32'h0b);
    ls(`USBRP_LS_SE0, `USBRP_LS_SE0);
    apb(0, `USBRP_APB_STAT, 0, 32'h1f, e);
    ls(`USBRP_LS_J, `USBRP_LS_J);
  end
  endtask
  // ----
  // Sequence
  // ----
  initial
  begin
    repeat (20) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    apb(0, `USBRP_APB_STAT, 0, 32'h1f, 32'h0);
    apb(0, `USBRP_APB_CTRL, 0, 32'hffffffff, `USBRP_CTRL_RST);
    apb(1, 12'h00c, 32'hffffffff, 0, 0);
    apb(0, 12'h00c, 0, 32'hffffffff, 32'h0);
    $display("test reset done");
    chip_reset_n <= 1;
    repeat (10) @(posedge pclk);
    apb(0, `USBRP_APB_STAT, 0, 32'h1f, 32'h09);
    repeat (30) @(posedge pclk);
    apb(0, `USBRP_APB_STAT, 0, 32'h1f, 32'h0a);
    enable <= 1;
    repeat (8) @(posedge pclk);
    apb(0, `USBRP_APB_STAT, 0, 32'h1f, 32'h0b);
    $display("test startup done");
    // Inhibit keeps bypass even after a full handshake
    apb(1, `USBRP_APB_CTRL, 32'h1, 0, 0);
    chirp(32'h0b);
    apb(1, `USBRP_APB_CTRL, 32'h0, 0, 0);
    enable <= 0;
    repeat (8) @(posedge pclk);
    apb(0, `USBRP_APB_STAT, 0, 32'h1f, 32'h0a);
    enable <= 1;
    repeat (8) @(posedge pclk);
    chirp(32'h14);
    enable <= 0;
    repeat (8) @(posedge pclk);
    apb(0, `USBRP_APB_STAT, 0, 32'h1f, 32'h0a);
    $display("test handshake done");
    serial_config_select <= 1;
    tx_current_trim_in <= 5'h0d;
    repeat (2) @(posedge pclk);
    chk("serial", 5'h0d, {serial_sda_in, serial_scl_in, serial_slave_addr});
    chk("trim out", 5'h00, trim_out);
    chk("trim oe_n", 5'h1f, trim_oe_n);
    apb(0, `USBRP_APB_STAT, 0, 32'h40, 32'h40);
    chip_reset_n <= 0;
    repeat (8) @(posedge pclk);
    apb(0, `USBRP_APB_STAT, 0, 32'h1f, 32'h0);
    chk("hiz", 1, outer_port_hiz);
    $display("test serial and reset done");
    final_report;
  end
endmodule
bind usbrp_path_ctrl usbrp_monitor u_mon (.pclk, .presetn, .chip_reset_n,
  .enable, .force_through_strap, .serial_config_select, .tx_current_trim_in,
  .serial_slave_addr, .serial_scl_in, .serial_sda_in, .bypass_path_on,
  .highspeed_resync_path, .outer_port_hiz, .state_indicator_out,
  .state_indicator_oe_n);
